/* pkg/spc_pkg.sv */
// Purpose: Constants for the parallel port clocking block of the serializer.
// Assumes: 125 MHz system clock; APB with 32-bit data.
// Notes:   Offsets are byte addresses, one aligned word per register.
package spc_pkg;
  // ==========================================================================
  // Register map
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_INT_STAT  = 8'h08;
  localparam logic [7:0] ADDR_INT_MASK  = 8'h0C;
  localparam logic [7:0] ADDR_TX_CHAR   = 8'h10;

  // ==========================================================================
  // Control register fields
  localparam int CTRL_CLK_SEL    = 0;  // tx_clock_select latch
  localparam int CTRL_RATE_SEL   = 1;  // tx_rate_select latch
  localparam int CTRL_REF_HALF   = 2;  // Reference clock half-rate mode
  localparam int CTRL_RX_HALF    = 3;  // Receive half-rate clocking
  localparam int CTRL_RX_BIST    = 4;  // Receive BIST enable
  localparam int CTRL_PLL_DOWN   = 5;  // Transmit PLL powered down
  localparam int CTRL_RECENTER   = 6;  // phase_buffer_recenter latch
  localparam int CTRL_W          = 7;
  localparam logic [6:0] CTRL_RESET = 7'h40;

  // ==========================================================================
  // Status and interrupt fields
  localparam int STAT_TX_ERR     = 0;
  localparam int STAT_BUF_FAULT  = 1;
  localparam int STAT_REF_LOST   = 2;
  localparam int STAT_PRIMED     = 3;
  localparam int INT_BUF_FAULT   = 0;
  localparam int INT_REF_LOST    = 1;
  localparam int INT_W           = 2;
  localparam logic [1:0] INT_MASK_RESET = 2'h0;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS      = 8;
  localparam int REF_TIMEOUT_NS     = 500;  // Longest gap before ref is absent
  localparam int REF_TIMEOUT_CYC    = REF_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int RX_CLK_HIGH_NS     = 16;   // Least high time of recovered clock
  localparam int RX_CLK_HIGH_CYC    = (RX_CLK_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : spc_pkg

/* verilog/spc_port_clocking.sv */
// Purpose: Transmit capture, phase-align buffer, tx clock synthesis and
//          receive character output of the serializer parallel port.
// Assumes: External clocks are sampled by clk; rx characters come from
//          the deserializer on clk.
// Notes:   Buffer depth is a parameter; ref edges pace the character clock.
//
// What this block does
// - Reference clock paces transmit and may be the transmit capture clock.
// - Clock-select 0 captures characters with the host transmit input clock.
// - Initialized buffer absorbs host clock drift up to half the buffer depth in character cycles.
// - Drift beyond buffer capacity raises the error flag until re-initialized or clock-select 1 is set.
// - Writing 0 to the recenter latch initializes the buffer phase.
// - Error flag from a buffer fault falls once the buffer is initialized or clock-select is 1.
// - Transmit clock output comes from the ref edges, not the character clock.
// - Transmit clock output at ref frequency when rate is 0, twice when 1.
// - Full-rate receive drives characters on each true recovered clock rise.
// - Half-rate receive clock runs at half rate, data on both edges.
// - With receive BIST on, status replaces data bits 1:0 plus status flag.
// - Half-rate reference samples transmit characters on both ref edges.
// - Half-rate reference updates the error output on both ref edges.
// - Characters are captured on the rising edge of the selected clock, or on both ref edges in half-rate reference mode.
// - Error flag also high with PLL powered down or reference absent.
`timescale 1ns/1ps
module spc_port_clocking
  import spc_pkg::*;
#(
  parameter int BUF_DEPTH = 4
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        ref_clock_in,
  input  wire logic        host_tx_input_clock,
  input  wire logic [9:0]  tx_char_in,
  output logic      [9:0]  txCharOut,
  output logic             txCharValid,
  output logic             tx_clock_out,
  output logic             tx_path_error,
  input  wire logic [9:0]  rxCharIn,
  input  wire logic        rxCharValid,
  input  wire logic [2:0]  bistStatusIn,
  output logic      [9:0]  rx_char_out,
  output logic             recovered_clock_out,
  output logic             recoveredClockOutN,
  output logic             bist_status_flag
);
  // Depth must be a power of two so the pointers wrap by themselves
  if (BUF_DEPTH < 2 || BUF_DEPTH > 16 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin : g_depth
    $error("BUF_DEPTH must be a power of two from 2 to 16");
  end
  localparam int PW = $clog2(BUF_DEPTH);

  // ==========================================================================
  // Pin synchronisers: stage 0 is read only by stage 1
  logic [1:0] refSync_q, hostSync_q;
  logic       refDly_q, hostDly_q;
  logic [9:0] txMeta_q, txSync_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      refSync_q  <= 2'h0;
      hostSync_q <= 2'h0;
      refDly_q   <= 1'b0;
      hostDly_q  <= 1'b0;
      txMeta_q   <= 10'h000;
      txSync_q   <= 10'h000;
    end else begin
      refSync_q  <= {refSync_q[0], ref_clock_in};
      hostSync_q <= {hostSync_q[0], host_tx_input_clock};
      refDly_q   <= refSync_q[1];
      hostDly_q  <= hostSync_q[1];
      txMeta_q   <= tx_char_in;
      txSync_q   <= txMeta_q;
    end
  end

  // ==========================================================================
  // Control and status registers
  logic [CTRL_W-1:0] ctrl_q;
  logic [INT_W-1:0]  intStat_q, intMask_q;
  logic              bufFault_q, refLost_q, primed_q;
  logic [7:0]        refGap_q;
  logic              wrAcc, rdAcc, recenterPulse;
  assign wrAcc = psel && penable && pready && pwrite;
  assign rdAcc = psel && penable && pready && !pwrite;
  // Recenter fires only on a write of 0 to the latch
  assign recenterPulse = wrAcc && paddr == ADDR_CTRL && !pwdata[CTRL_RECENTER];

  logic refRise, refFall, hostRise, refTick, selRef, refHalf;
  assign refRise  = refSync_q[1] && !refDly_q;
  assign refFall  = !refSync_q[1] && refDly_q;
  assign hostRise = hostSync_q[1] && !hostDly_q;
  assign selRef   = ctrl_q[CTRL_CLK_SEL];
  assign refHalf  = ctrl_q[CTRL_REF_HALF];
  // Character clock: ref rise, or both edges in half-rate mode
  assign refTick  = refRise || (refHalf && refFall);

  // Control latch; writes take effect at the edge that samples pready
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q    <= CTRL_RESET;
      intMask_q <= INT_MASK_RESET;
    end else if (wrAcc) begin
      if (paddr == ADDR_CTRL) ctrl_q <= pwdata[CTRL_W-1:0];
      if (paddr == ADDR_INT_MASK) intMask_q <= pwdata[INT_W-1:0];
    end
  end

  // ==========================================================================
  // APB slave: three-cycle access with one wait state, unmapped address answers with pslverr
  logic mapped;
  assign mapped = paddr inside {ADDR_CTRL, ADDR_STATUS, ADDR_INT_STAT, ADDR_INT_MASK,
                                ADDR_TX_CHAR};
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (psel && penable && !pready && !pwrite) begin
        unique case (paddr)
          ADDR_CTRL:     prdata <= {25'h0, ctrl_q};
          ADDR_STATUS:   prdata <= {28'h0, primed_q, refLost_q, bufFault_q, tx_path_error};
          ADDR_INT_STAT: prdata <= {30'h0, intStat_q};
          ADDR_INT_MASK: prdata <= {30'h0, intMask_q};
          ADDR_TX_CHAR:  prdata <= {22'h0, txCharOut};
          default:       prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================================
  // Phase-align buffer, written on host rise, read on the character clock
  logic [9:0] bufMem_q [BUF_DEPTH];
  logic [PW-1:0] wrPtr_q, rdPtr_q;
  logic [PW:0]   fill_q;
  logic          bufWr, bufRd, overflow, underflow;
  assign bufWr     = !selRef && hostRise && !recenterPulse;
  assign bufRd     = !selRef && refTick && primed_q && !recenterPulse;
  assign overflow  = bufWr && !bufRd && fill_q == (PW+1)'(BUF_DEPTH);
  assign underflow = bufRd && !bufWr && fill_q == '0;
  always_ff @(posedge clk) begin
    if (bufWr) bufMem_q[wrPtr_q] <= txSync_q;
  end
  // Reads wait for half the depth, so half the depth in character cycles of drift either way fits
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrPtr_q  <= '0;
      rdPtr_q  <= '0;
      fill_q   <= '0;
      primed_q <= 1'b0;
    end else if (recenterPulse) begin
      wrPtr_q  <= '0;
      rdPtr_q  <= '0;
      fill_q   <= '0;
      primed_q <= 1'b0;
    end else begin
      if (bufWr && !overflow) wrPtr_q <= wrPtr_q + 1'b1;
      if (bufRd && !underflow) rdPtr_q <= rdPtr_q + 1'b1;
      if (bufWr && !overflow && !(bufRd && !underflow)) fill_q <= fill_q + 1'b1;
      else if (bufRd && !underflow && !bufWr) fill_q <= fill_q - 1'b1;
      if (!selRef && fill_q >= (PW+1)'(BUF_DEPTH / 2)) primed_q <= 1'b1;
    end
  end

  // Sticky buffer fault, cleared only by re-initializing the buffer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) bufFault_q <= 1'b0;
    else if (recenterPulse) bufFault_q <= 1'b0;
    else if (overflow || underflow) bufFault_q <= 1'b1;
  end

  // Captured character toward the serializer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      txCharOut   <= 10'h000;
      txCharValid <= 1'b0;
    end else begin
      txCharValid <= (selRef && refTick) || (bufRd && !underflow);
      if (selRef && refTick) txCharOut <= txSync_q;
      else if (bufRd && !underflow) txCharOut <= bufMem_q[rdPtr_q];
    end
  end

  // ==========================================================================
  // Reference presence watchdog
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      refGap_q  <= 8'h00;
      refLost_q <= 1'b0;
    end else if (refRise || refFall) begin
      refGap_q  <= 8'h00;
      refLost_q <= 1'b0;
    end else if (refGap_q == 8'(REF_TIMEOUT_CYC)) begin
      refLost_q <= 1'b1;
    end else begin
      refGap_q  <= refGap_q + 8'h01;
    end
  end

  // Error output: fault moves on the character clock, PLL or ref loss at once
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) tx_path_error <= 1'b0;
    else if (ctrl_q[CTRL_PLL_DOWN] || refLost_q) tx_path_error <= 1'b1;
    else if (refTick) tx_path_error <= bufFault_q && !selRef;
  end

  // Sticky interrupt flags; each is set once, in the cycle its event starts
  logic [INT_W-1:0] intSet;
  assign intSet = {!refLost_q && refGap_q == 8'(REF_TIMEOUT_CYC) && !(refRise || refFall),
                   (overflow || underflow) && !bufFault_q};
  // A read clears only the bits it reported, so an event after the snapshot survives
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      intStat_q <= '0;
      irq       <= 1'b0;
    end else begin
      intStat_q <= ((rdAcc && paddr == ADDR_INT_STAT) ? intStat_q & ~prdata[INT_W-1:0]
                                                      : intStat_q) | intSet;
      irq       <= |(intStat_q & intMask_q);
    end
  end

  // ==========================================================================
  // Transmit clock synthesis from the reference clock edges
  logic [7:0] halfGap_q, sinceEdge_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_clock_out <= 1'b0;
      halfGap_q    <= 8'h00;
      sinceEdge_q  <= 8'h00;
    end else if (refRise || refFall) begin
      halfGap_q    <= sinceEdge_q;
      sinceEdge_q  <= 8'h00;
      // Rate 1 rises at every ref edge; rate 0 simply follows the ref
      tx_clock_out <= ctrl_q[CTRL_RATE_SEL] ? 1'b1 : refRise;
    end else begin
      sinceEdge_q  <= sinceEdge_q + 8'h01;
      if (ctrl_q[CTRL_RATE_SEL] && sinceEdge_q == (halfGap_q >> 1)) tx_clock_out <= 1'b0;
    end
  end

  // ==========================================================================
  // Receive output and recovered clock pair
  logic       rxHalf_q;
  logic [1:0] rxHigh_q;
  // Rate mode is taken only while no character is being delivered
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) rxHalf_q <= 1'b0;
    else if (!rxCharValid && rxHigh_q == 2'h0) rxHalf_q <= ctrl_q[CTRL_RX_HALF];
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_char_out         <= 10'h000;
      bist_status_flag    <= 1'b0;
      recovered_clock_out <= 1'b0;
      recoveredClockOutN  <= 1'b1;
      rxHigh_q            <= 2'h0;
    end else if (rxCharValid) begin
      rx_char_out[9:2] <= rxCharIn[9:2];
      // BIST status takes over the low bits
      rx_char_out[1:0] <= ctrl_q[CTRL_RX_BIST] ? bistStatusIn[1:0] : rxCharIn[1:0];
      bist_status_flag <= ctrl_q[CTRL_RX_BIST] && bistStatusIn[2];
      if (rxHalf_q) begin
        recovered_clock_out <= !recovered_clock_out;
        recoveredClockOutN  <= recovered_clock_out;
      end else begin
        recovered_clock_out <= 1'b1;
        recoveredClockOutN  <= 1'b0;
        rxHigh_q            <= 2'(RX_CLK_HIGH_CYC);
      end
    end else if (rxHigh_q != 2'h0) begin
      rxHigh_q <= rxHigh_q - 2'h1;
      if (rxHigh_q == 2'h1) begin
        recovered_clock_out <= 1'b0;
        recoveredClockOutN  <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Assertions
  a_fault_sticky: assert property (@(posedge clk) disable iff (sys_rst)
    bufFault_q && !recenterPulse |=> bufFault_q) else $error("buffer fault dropped");
  a_recenter_clear: assert property (@(posedge clk) disable iff (sys_rst)
    recenterPulse |=> !bufFault_q && fill_q == '0) else $error("recenter failed");
  a_err_low_ok: assert property (@(posedge clk) disable iff (sys_rst)
    refTick && !ctrl_q[CTRL_PLL_DOWN] && !refLost_q && bufFault_q && !selRef
    |=> tx_path_error) else $error("error low with fault");
  a_pll_down: assert property (@(posedge clk) disable iff (sys_rst)
    ctrl_q[CTRL_PLL_DOWN] |=> tx_path_error) else $error("pll down not flagged");
  a_ref_lost: assert property (@(posedge clk) disable iff (sys_rst)
    !(refRise || refFall) [*8] ##0 refGap_q == 8'(REF_TIMEOUT_CYC) |-> ##[1:2] tx_path_error)
    else $error("ref loss not flagged");
  a_ref_capture: assert property (@(posedge clk) disable iff (sys_rst)
    selRef && refTick |=> txCharValid && txCharOut == $past(txSync_q))
    else $error("ref capture wrong");
  a_host_order: assert property (@(posedge clk) disable iff (sys_rst)
    selRef && !recenterPulse |=> wrPtr_q == $past(wrPtr_q))
    else $error("buffer written in ref mode");
  a_rate_follow: assert property (@(posedge clk) disable iff (sys_rst)
    !ctrl_q[CTRL_RATE_SEL] && refFall |=> !tx_clock_out) else $error("rate 0 clock wrong");
  a_rx_full: assert property (@(posedge clk) disable iff (sys_rst)
    rxCharValid && !rxHalf_q |=> recovered_clock_out && !recoveredClockOutN)
    else $error("full rate clock wrong");
  a_rx_half: assert property (@(posedge clk) disable iff (sys_rst)
    rxCharValid && rxHalf_q |=> recovered_clock_out != $past(recovered_clock_out))
    else $error("half rate clock wrong");
  a_bist_bits: assert property (@(posedge clk) disable iff (sys_rst)
    rxCharValid && ctrl_q[CTRL_RX_BIST] |=> rx_char_out[1:0] == $past(bistStatusIn[1:0]))
    else $error("bist bits wrong");
endmodule : spc_port_clocking

/* dv/spc_host_model.sv */
// Purpose: Host co-processor side: transmit input clock and characters.
// Assumes: Same period as the reference clock, phase set by start time.
// Notes:   Characters step on the falling edge so they are stable at rise.
`timescale 1ns/1ps
// ==========================================================================
// Host model
module spc_host_model (
  input  wire logic       run,
  output logic            host_tx_input_clock,
  output logic [9:0]      tx_char_in
);
  // Frequency equal to the device output, phase left free
  initial begin
    host_tx_input_clock = 1'b0;
    tx_char_in          = 10'h155;
    forever begin
      if (run) begin
        #80 host_tx_input_clock = 1'b1;
        #80 host_tx_input_clock = 1'b0;
        tx_char_in = tx_char_in + 10'h001;  // Change at the fall keeps setup and hold wide
      end else begin
        host_tx_input_clock = 1'b0;  // Pin pull-down holds a stopped clock low
        @(posedge run);
      end
    end
  end
endmodule : spc_host_model

/* dv/spc_port_clocking_tb.sv */
// Purpose: Self-checking bench for the parallel port clocking block.
// Assumes: 125 MHz clk, 160 ns reference and host clocks, APB access.
// Notes:   Rates are judged by edge counts over a 1000-cycle window.
`timescale 1ns/1ps
module spc_port_clocking_tb;
  import spc_pkg::*;
  logic clk, sys_rst, psel, penable, pwrite, refClk, refRun, hostRun, rxCharValid;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, irq, hostClk, txCharValid, tx_clock_out, tx_path_error;
  logic [9:0] hostChar, txCharOut, rxCharIn, rx_char_out, firstChar;
  logic [2:0] bistStatusIn;
  logic recovered_clock_out, recoveredClockOutN, bist_status_flag, err;
  int failCount, numChecks, nTx, nVal;
  // ==========================================================================
  // Clocks, design and partner
  initial clk = 1'b0;
  always #4 clk = ~clk;
  initial refClk = 1'b0;
  // Reference stands still while absent
  always #80 if (refRun) refClk = ~refClk;
  spc_port_clocking #(.BUF_DEPTH(4)) DUT (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .ref_clock_in(refClk),
    .host_tx_input_clock(hostClk), .tx_char_in(hostChar), .txCharOut(txCharOut),
    .txCharValid(txCharValid), .tx_clock_out(tx_clock_out), .tx_path_error(tx_path_error),
    .rxCharIn(rxCharIn), .rxCharValid(rxCharValid), .bistStatusIn(bistStatusIn),
    .rx_char_out(rx_char_out), .recovered_clock_out(recovered_clock_out),
    .recoveredClockOutN(recoveredClockOutN), .bist_status_flag(bist_status_flag));
  spc_host_model HOST (.run(hostRun), .host_tx_input_clock(hostClk), .tx_char_in(hostChar));
  // ==========================================================================
  // Reporting
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("wrong value at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  // ==========================================================================
  // APB master; waits for pready with a bound, no fixed latency assumed
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin failCount++; end_of_test; end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    // One idle cycle so the next call never re-drives psel in this time step
    @(posedge clk);
  endtask : apb
  // Bounded wait for a captured character
  task automatic wait_valid;
    int n;
    n = 0;
    do begin @(posedge clk); n++; end while (txCharValid !== 1'b1 && n < 300);
    if (n >= 300) begin failCount++; end_of_test; end
  endtask : wait_valid
  // Count tx clock rises and captures over 50 reference periods
  task automatic measure;
    logic prev;
    nTx = 0; nVal = 0; prev = tx_clock_out;
    repeat (1000) begin
      @(posedge clk);
      if (tx_clock_out === 1'b1 && prev === 1'b0) nTx++;
      if (txCharValid === 1'b1) nVal++;
      prev = tx_clock_out;
    end
  endtask : measure
  // One received character; half selects the toggling clock check
  task automatic rx_send(input logic [9:0] c, input logic [9:0] exp, input logic half);
    logic prev;
    prev = recovered_clock_out;
    rxCharIn <= c; rxCharValid <= 1'b1;
    @(posedge clk);
    rxCharValid <= 1'b0;
    #1;
    check(rx_char_out, exp);
    if (half) check(recovered_clock_out, !prev);
    else check({recovered_clock_out, recoveredClockOutN}, 2'b10);
    repeat (8) @(posedge clk);
  endtask : rx_send
  // ==========================================================================
  // Main sequence
  initial begin
    failCount = 0; numChecks = 0; sys_rst = 1'b1; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; refRun = 1'b0; hostRun = 1'b0;
    rxCharValid = 1'b0; rxCharIn = 10'h000; bistStatusIn = 3'b000;
    #3 refRun = 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, ADDR_CTRL, 32'h0); check(rd, 32'h40);
    apb(1'b0, 8'h20, 32'h0); check(err, 1'b1);
    check(rd, 32'h0);
    // Reference clock as capture clock, host stopped
    apb(1'b1, ADDR_CTRL, 32'h41);
    repeat (300) @(posedge clk);
    check(tx_path_error, 1'b0);
    wait_valid; check(txCharOut, hostChar);
    measure; check({nTx inside {[49:51]}, nVal inside {[49:51]}}, 2'b11);
    apb(1'b1, ADDR_CTRL, 32'h43);
    measure; check(nTx inside {[99:101]}, 1'b1);
    apb(1'b1, ADDR_CTRL, 32'h45);
    measure; check(nVal inside {[99:101]}, 1'b1);
    check(tx_path_error, 1'b0);
    // PLL down and reference loss
    apb(1'b1, ADDR_CTRL, 32'h61);
    repeat (3) @(posedge clk); check(tx_path_error, 1'b1);
    apb(1'b0, ADDR_STATUS, 32'h0); check(rd[STAT_TX_ERR], 1'b1);
    apb(1'b1, ADDR_CTRL, 32'h41); apb(1'b1, ADDR_INT_MASK, 32'h0);
    repeat (40) @(posedge clk); check(tx_path_error, 1'b0);
    refRun = 1'b0;
    repeat (100) @(posedge clk); check({tx_path_error, irq}, 2'b10);
    apb(1'b1, ADDR_INT_MASK, 32'h2);
    repeat (3) @(posedge clk); check(irq, 1'b1);
    refRun = 1'b1;
    repeat (40) @(posedge clk);
    apb(1'b0, ADDR_INT_STAT, 32'h0); check(rd[INT_REF_LOST], 1'b1);
    repeat (3) @(posedge clk); check(irq, 1'b0);
    // Host clock capture through the phase-align buffer
    hostRun = 1'b1;
    apb(1'b1, ADDR_CTRL, 32'h00); apb(1'b1, ADDR_CTRL, 32'h40);
    repeat (400) @(posedge clk); check(tx_path_error, 1'b0);
    apb(1'b0, ADDR_STATUS, 32'h0); check(rd[STAT_PRIMED], 1'b1);
    wait_valid; firstChar = txCharOut;
    wait_valid; check(txCharOut, firstChar + 10'h001);
    apb(1'b1, ADDR_INT_MASK, 32'h1);
    hostRun = 1'b0;
    repeat (150) @(posedge clk); check({tx_path_error, irq}, 2'b11);
    hostRun = 1'b1;
    repeat (300) @(posedge clk); check(tx_path_error, 1'b1);
    apb(1'b0, ADDR_INT_STAT, 32'h0); check(rd[INT_BUF_FAULT], 1'b1);
    apb(1'b1, ADDR_CTRL, 32'h00); apb(1'b1, ADDR_CTRL, 32'h40);
    repeat (400) @(posedge clk); check(tx_path_error, 1'b0);
    // Receive side: full rate, half rate, BIST overlay
    rx_send(10'h2A5, 10'h2A5, 1'b0);
    rx_send(10'h15A, 10'h15A, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h48); repeat (8) @(posedge clk);
    rx_send(10'h3C3, 10'h3C3, 1'b1);
    rx_send(10'h03C, 10'h03C, 1'b1);
    apb(1'b1, ADDR_CTRL, 32'h50); repeat (8) @(posedge clk);
    bistStatusIn <= 3'b101;
    rx_send(10'h3FC, 10'h3FD, 1'b0);
    check(bist_status_flag, 1'b1);
    end_of_test;
  end
  // Hang guard
  initial begin
    #400000;
    failCount++;
    end_of_test;
  end
endmodule : spc_port_clocking_tb
